// *** src/clkbuf_cfg_pkg.sv ***
`default_nettype none
package clkbuf_cfg_pkg;
  // Byte locations of the bank
  localparam logic [7:0] FREQ_SLEW_OFS = 8'h03;
  localparam logic [7:0] RSVD_A_OFS = 8'h04;
  localparam logic [7:0] REV_VENDOR_OFS = 8'h05;
  localparam logic [7:0] DEV_TYPE_OFS = 8'h06;
  localparam logic [7:0] READ_COUNT_OFS = 8'h07;
  localparam logic [7:0] RSVD_B_OFS = 8'h08;
  localparam logic [7:0] RSVD_C_OFS = 8'h09;
  localparam logic [7:0] PD_RETAIN_OFS = 8'h0a;
  localparam logic [7:0] STOP_FB_IMP_OFS = 8'h0b;
  localparam logic [7:0] OUT0_IMP_OFS = 8'h0c;

  // Field positions
  localparam int FREQ_EN_BIT = 5;
  localparam int FREQ_HI_BIT = 4;
  localparam int FREQ_LO_BIT = 3;
  localparam int FB_SLEW_BIT = 0;
  localparam int RETAIN_BIT = 6;
  localparam int IMP_HI_BIT = 7;
  localparam int IMP_LO_BIT = 6;
  localparam int STOP_HI_BIT = 1;
  localparam int STOP_LO_BIT = 0;
  localparam int COUNT_HI_BIT = 4;

  // Writable bits per byte; everything else keeps its default
  localparam logic [7:0] FREQ_SLEW_WMASK = 8'h39;
  localparam logic [7:0] DEV_TYPE_WMASK = 8'hff;
  localparam logic [7:0] READ_COUNT_WMASK = 8'h1f;
  localparam logic [7:0] PD_RETAIN_WMASK = 8'h40;
  localparam logic [7:0] STOP_FB_IMP_WMASK = 8'hc3;
  localparam logic [7:0] OUT0_IMP_WMASK = 8'hc0;

  // Values after reset (impedance bits filled per variant)
  localparam logic [7:0] FREQ_SLEW_RST = 8'hc5;
  localparam logic [7:0] READ_COUNT_RST = 8'h08;
  localparam logic [7:0] PD_RETAIN_RST = 8'h40;
  localparam logic [7:0] STOP_FB_IMP_RST = 8'h00;
  localparam logic [7:0] OUT0_IMP_RST = 8'h00;
  localparam logic [1:0] FREQ_APPLIED_RST = 2'h0;

  // Arbitrary identity values
  localparam logic [3:0] REVISION_CODE = 4'h3;
  localparam logic [3:0] VENDOR_CODE = 4'ha;
  localparam logic [1:0] PART_CATEGORY = 2'h3;
  localparam logic [5:0] PART_IDENTIFIER = 6'h05;

  // Encodings
  localparam logic [1:0] FREQ_RESERVED = 2'h3;
  localparam logic [1:0] IMP_33 = 2'h0;
  localparam logic [1:0] IMP_85 = 2'h1;
  localparam logic [1:0] IMP_100 = 2'h2;
  localparam logic [1:0] STOP_LOW_LOW = 2'h0;
  localparam logic [1:0] STOP_HIZ = 2'h1;
  localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
  localparam logic [1:0] STOP_LOW_HIGH = 2'h3;
  localparam logic [1:0] VARIANT_100 = 2'h0;
  localparam logic [1:0] VARIANT_85 = 2'h1;
  localparam logic [1:0] VARIANT_FACTORY = 2'h2;

  // Serial framing
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_INDEX = 2'h1;
  localparam logic [1:0] BYTE_COUNT = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} link_state_t;
endpackage : clkbuf_cfg_pkg
`default_nettype wire

// *** src/clock_buffer_config_regs.sv ***
// What this block does
// - Software frequency-change enable bit, 1 enables, resets to 0.
// - Frequency select 00=100M, 01=50M, 10=125M, 11 reserved; applied only when enabled.
// - Feedback slew bit: 0 slow, 1 fast, resets to 1.
// - Read-only identity byte: revision code high nibble, vendor code low nibble.
// - Device type byte: 2-bit category on top, 6-bit identifier below.
// - Writable 5-bit readback length is sent as the block-read byte count, defaults to 8; the host's refusal ends the read.
// - Retain bit: 0 clears config in power-down, 1 keeps it; resets to 1.
// - Stop-state field: 00 low/low, 01 hi-z, 10 high/low, 11 low/high.
// - Feedback impedance in top two bits: 33, 85, 100 ohm, 11 reserved.
// - Output0 impedance in top bits of own byte, same coding; rest reserved.
// - Impedance resets: 01 on 85-ohm variant, factory on the factory variant, 10 otherwise.
// - Byte locations 4, 8 and 9 are reserved, no function.
// - Block read sends byte count first, then data from the chosen index.
// - Output0 enable bit low overrides pin and forces the stop state.
`default_nettype none
module clock_buffer_config_regs
  import clkbuf_cfg_pkg::*;
#(
  parameter logic [1:0] IMP_VARIANT = VARIANT_100,
  parameter logic [1:0] FACTORY_FB_IMP = IMP_100,
  parameter logic [1:0] FACTORY_OUT0_IMP = IMP_100
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Serial management link
  input wire logic [6:0] i_slave_addr,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Power and output control
  input wire logic i_powerdown,
  input wire logic i_output0_enable_bit,
  input wire logic i_out0_pin_enable,
  // Configuration to the clock path
  output logic [1:0] o_freq_pick,
  output logic o_feedback_edge_speed,
  output logic [1:0] o_feedback_out_impedance,
  output logic [1:0] o_output0_impedance_sel,
  output logic [1:0] o_stopped_output_levels,
  output logic o_powerdown_config_retain,
  // Output0 stop-state drive
  output logic o_out0_stopped,
  output logic o_out0_true_level,
  output logic o_out0_comp_level,
  output logic o_out0_hiz
);

  typedef struct packed {
    link_state_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] byte_no;
    logic is_read;
    logic ack_drive;
    logic host_nak;
    logic [7:0] index;
    logic [7:0] freq_slew;
    logic [7:0] dev_type;
    logic [7:0] read_count;
    logic [7:0] pd_retain;
    logic [7:0] stop_fb_imp;
    logic [7:0] out0_imp;
    logic [1:0] freq_applied;
    logic out0_stopped;
    logic out0_true;
    logic out0_comp;
    logic out0_hiz;
  } state_t;

  // Impedance default depends on the built variant
  localparam logic [1:0] FB_IMP_DEF = (IMP_VARIANT == VARIANT_85) ? IMP_85 :
    (IMP_VARIANT == VARIANT_FACTORY) ? FACTORY_FB_IMP : IMP_100;
  localparam logic [1:0] OUT0_IMP_DEF = (IMP_VARIANT == VARIANT_85) ? IMP_85 :
    (IMP_VARIANT == VARIANT_FACTORY) ? FACTORY_OUT0_IMP : IMP_100;
  localparam logic [7:0] STOP_FB_DEF = STOP_FB_IMP_RST | {FB_IMP_DEF, 6'h00};
  localparam logic [7:0] OUT0_DEF = OUT0_IMP_RST | {OUT0_IMP_DEF, 6'h00};
  localparam logic [7:0] DEV_TYPE_RST = {PART_CATEGORY, PART_IDENTIFIER};
  // Bit counter parked here after a start, so the start's own clock fall
  // wraps it to zero instead of being counted as a data bit
  localparam logic [3:0] PRE_FIRST = 4'hf;

  localparam state_t RESET_STATE = '{
    st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, bitcnt: 4'h0, shreg: 8'h00,
    byte_no: BYTE_ADDR, is_read: 1'b0, ack_drive: 1'b0, host_nak: 1'b0,
    index: 8'h00, freq_slew: FREQ_SLEW_RST, dev_type: DEV_TYPE_RST,
    read_count: READ_COUNT_RST, pd_retain: PD_RETAIN_RST,
    stop_fb_imp: STOP_FB_DEF, out0_imp: OUT0_DEF,
    freq_applied: FREQ_APPLIED_RST, out0_stopped: 1'b0,
    out0_true: 1'b0, out0_comp: 1'b0, out0_hiz: 1'b0};

  state_t s_r;
  state_t s_nxt;

  // Masked update keeps reserved bits at their defaults
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                       input logic [7:0] m);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  // Readback mux; unimplemented and reserved locations return zero
  function automatic logic [7:0] read_byte(input state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      FREQ_SLEW_OFS: v = s.freq_slew;
      REV_VENDOR_OFS: v = {REVISION_CODE, VENDOR_CODE};
      DEV_TYPE_OFS: v = s.dev_type;
      READ_COUNT_OFS: v = s.read_count;
      PD_RETAIN_OFS: v = s.pd_retain;
      STOP_FB_IMP_OFS: v = s.stop_fb_imp;
      OUT0_IMP_OFS: v = s.out0_imp;
      default: v = 8'h00;
    endcase
    read_byte = v;
  endfunction : read_byte

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic tx_pull;

  // Bus conditions from the previous sample of both lines
  assign start_cond = s_r.scl_q & i_scl & s_r.sda_q & ~i_sda;
  assign stop_cond = s_r.scl_q & i_scl & ~s_r.sda_q & i_sda;
  assign scl_rise = ~s_r.scl_q & i_scl;
  assign scl_fall = s_r.scl_q & ~i_scl;

  // Sent bits only pull low; a one is left to the pull-up
  assign tx_pull = s_r.st == ST_TX && s_r.bitcnt < ACK_SLOT && !s_r.shreg[7];

  // Next-state logic for link, register bank and outputs
  always_comb begin
    s_nxt = s_r;
    // One sample of both lines kept for edge detection
    s_nxt.scl_q = i_scl;
    s_nxt.sda_q = i_sda;
    if (start_cond) begin
      // Repeated start keeps the index so a read follows the pointer write
      s_nxt.st = ST_RX;
      s_nxt.bitcnt = PRE_FIRST;
      s_nxt.byte_no = BYTE_ADDR;
      s_nxt.ack_drive = 1'b0;
      s_nxt.host_nak = 1'b0;
    end else if (stop_cond) begin
      s_nxt.st = ST_IDLE;
      s_nxt.ack_drive = 1'b0;
    end else if (s_r.st != ST_IDLE) begin
      // Bits and the host acknowledge are taken on the rising clock
      if (scl_rise) begin
        if (s_r.bitcnt < ACK_SLOT && s_r.st == ST_RX) begin
          s_nxt.shreg = {s_r.shreg[6:0], i_sda};
        end
        if (s_r.bitcnt == ACK_SLOT && s_r.st == ST_TX) begin
          s_nxt.host_nak = i_sda;
        end
      end else if (scl_fall) begin
        // Anything that moves the data line waits for the falling clock
        if (s_r.bitcnt == LAST_BIT) begin
          s_nxt.bitcnt = ACK_SLOT;
          if (s_r.st == ST_RX) begin
            s_nxt.ack_drive = 1'b1;
            unique case (s_r.byte_no)
              BYTE_ADDR: begin
                // Upper seven bits are the address, bit 0 the direction
                if (s_r.shreg[7:1] == i_slave_addr) begin
                  s_nxt.is_read = s_r.shreg[0];
                  s_nxt.byte_no = BYTE_INDEX;
                end else begin
                  // Not our address: stay off the bus until the next start
                  s_nxt.ack_drive = 1'b0;
                  s_nxt.st = ST_IDLE;
                end
              end
              BYTE_INDEX: begin
                // Pointer for the writes that follow and for a later read
                s_nxt.index = s_r.shreg;
                s_nxt.byte_no = BYTE_COUNT;
              end
              BYTE_COUNT: begin
                // Host count is accepted; bytes are written until stop
                s_nxt.byte_no = BYTE_DATA;
              end
              BYTE_DATA: begin
                // Pointer steps over ignored places too, so bursts stay aligned
                s_nxt.index = s_r.index + 8'h01;
                unique case (s_r.index)
                  FREQ_SLEW_OFS: s_nxt.freq_slew =
                    merge(s_r.freq_slew, s_r.shreg, FREQ_SLEW_WMASK);
                  DEV_TYPE_OFS: s_nxt.dev_type =
                    merge(s_r.dev_type, s_r.shreg, DEV_TYPE_WMASK);
                  READ_COUNT_OFS: s_nxt.read_count =
                    merge(s_r.read_count, s_r.shreg, READ_COUNT_WMASK);
                  PD_RETAIN_OFS: s_nxt.pd_retain =
                    merge(s_r.pd_retain, s_r.shreg, PD_RETAIN_WMASK);
                  STOP_FB_IMP_OFS: s_nxt.stop_fb_imp =
                    merge(s_r.stop_fb_imp, s_r.shreg, STOP_FB_IMP_WMASK);
                  OUT0_IMP_OFS: s_nxt.out0_imp =
                    merge(s_r.out0_imp, s_r.shreg, OUT0_IMP_WMASK);
                  default: s_nxt.index = s_r.index + 8'h01;
                endcase
              end
            endcase
          end else begin
            s_nxt.ack_drive = 1'b0; // Release for the host acknowledge
          end
        end else if (s_r.bitcnt == ACK_SLOT) begin
          // Ninth clock over: release the line and pick the next step
          s_nxt.bitcnt = 4'h0;
          s_nxt.ack_drive = 1'b0;
          if (s_r.st == ST_RX && s_r.is_read && s_r.byte_no == BYTE_INDEX) begin
            // Read address taken: the byte count goes out first
            s_nxt.st = ST_TX;
            s_nxt.host_nak = 1'b0;
            s_nxt.shreg = {3'h0, s_r.read_count[COUNT_HI_BIT:0]};
          end else if (s_r.st == ST_TX) begin
            // Host acknowledge continues the read, a refusal ends it
            if (s_r.host_nak) begin
              s_nxt.st = ST_IDLE;
            end else begin
              s_nxt.shreg = read_byte(s_r, s_r.index);
              s_nxt.index = s_r.index + 8'h01;
            end
          end
        end else begin
          // Plain data bit: count it and, when sending, expose the next one
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          if (s_r.st == ST_TX) begin
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
          end
        end
      end
    end

    // Frequency follows the select bits only while software may change it
    if (s_r.freq_slew[FREQ_EN_BIT] &&
        s_r.freq_slew[FREQ_HI_BIT:FREQ_LO_BIT] != FREQ_RESERVED) begin
      s_nxt.freq_applied = s_r.freq_slew[FREQ_HI_BIT:FREQ_LO_BIT];
    end

    // Disabled output0 is forced to the selected stop levels
    s_nxt.out0_stopped = ~i_output0_enable_bit | ~i_out0_pin_enable;
    unique case (s_r.stop_fb_imp[STOP_HI_BIT:STOP_LO_BIT])
      STOP_LOW_LOW: begin
        s_nxt.out0_true = 1'b0;
        s_nxt.out0_comp = 1'b0;
        s_nxt.out0_hiz = 1'b0;
      end
      STOP_HIZ: begin
        s_nxt.out0_true = 1'b0;
        s_nxt.out0_comp = 1'b0;
        s_nxt.out0_hiz = 1'b1;
      end
      STOP_HIGH_LOW: begin
        s_nxt.out0_true = 1'b1;
        s_nxt.out0_comp = 1'b0;
        s_nxt.out0_hiz = 1'b0;
      end
      STOP_LOW_HIGH: begin
        s_nxt.out0_true = 1'b0;
        s_nxt.out0_comp = 1'b1;
        s_nxt.out0_hiz = 1'b0;
      end
    endcase

    // Power-down without retention restores defaults; it wins over a write
    if (i_powerdown && !s_r.pd_retain[RETAIN_BIT]) begin
      s_nxt.freq_slew = FREQ_SLEW_RST;
      s_nxt.dev_type = DEV_TYPE_RST;
      s_nxt.read_count = READ_COUNT_RST;
      s_nxt.pd_retain = PD_RETAIN_RST;
      s_nxt.stop_fb_imp = STOP_FB_DEF;
      s_nxt.out0_imp = OUT0_DEF;
      s_nxt.freq_applied = FREQ_APPLIED_RST;
    end
  end

  // Single state register
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Open-drain data line: only ever pulled low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = s_r.ack_drive | tx_pull;

  // Outputs straight from the state register: bank fields, applied frequency and output0 stop drive
  assign o_freq_pick = s_r.freq_applied;
  assign o_feedback_edge_speed = s_r.freq_slew[FB_SLEW_BIT];
  assign o_feedback_out_impedance = s_r.stop_fb_imp[IMP_HI_BIT:IMP_LO_BIT];
  assign o_output0_impedance_sel = s_r.out0_imp[IMP_HI_BIT:IMP_LO_BIT];
  assign o_stopped_output_levels = s_r.stop_fb_imp[STOP_HI_BIT:STOP_LO_BIT];
  assign o_powerdown_config_retain = s_r.pd_retain[RETAIN_BIT];
  assign o_out0_stopped = s_r.out0_stopped;
  assign o_out0_true_level = s_r.out0_true;
  assign o_out0_comp_level = s_r.out0_comp;
  assign o_out0_hiz = s_r.out0_hiz;

endmodule : clock_buffer_config_regs
`default_nettype wire

// *** verification/clock_buffer_config_regs_properties.sv ***
`default_nettype none
module cfg_regs_checker
  import clkbuf_cfg_pkg::*;
(
  // Clock, reset and inputs
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_powerdown,
  input wire logic i_output0_enable_bit,
  input wire logic i_out0_pin_enable,
  // Outputs watched
  input wire logic o_sda_oe,
  input wire logic [1:0] o_freq_pick,
  input wire logic o_feedback_edge_speed,
  input wire logic o_powerdown_config_retain,
  input wire logic [1:0] o_stopped_output_levels,
  input wire logic o_out0_stopped,
  input wire logic o_out0_true_level,
  input wire logic o_out0_comp_level,
  input wire logic o_out0_hiz
);
  // Drive levels as one field
  logic [2:0] lv;
  assign lv = {o_out0_true_level, o_out0_comp_level, o_out0_hiz};
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  // Levels follow the field a cycle late; guard skips pre-reset history
  property stop_p(logic [1:0] c, logic [2:0] v);
    $past(i_nrst) && $past(o_stopped_output_levels) == c |-> lv == v;
  endproperty
  reset_values_a: assert property ($rose(i_nrst) |-> o_freq_pick == 2'h0
    && o_feedback_edge_speed && o_powerdown_config_retain && !o_sda_oe) else $error("reset");
  freq_legal_a: assert property (o_freq_pick != FREQ_RESERVED) else $error("freq 11");
  stop_low_a: assert property (stop_p(STOP_LOW_LOW, 3'b000)) else $error("stop 00");
  stop_hiz_a: assert property (stop_p(STOP_HIZ, 3'b001)) else $error("stop 01");
  stop_high_a: assert property (stop_p(STOP_HIGH_LOW, 3'b100)) else $error("stop 10");
  stop_comp_a: assert property (stop_p(STOP_LOW_HIGH, 3'b010)) else $error("stop 11");
  out0_override_a: assert property ($past(i_nrst) |-> o_out0_stopped ==
    !($past(i_output0_enable_bit) && $past(i_out0_pin_enable))) else $error("override");
  pd_clear_a: assert property (i_powerdown && !o_powerdown_config_retain |=>
    o_powerdown_config_retain && o_feedback_edge_speed && o_stopped_output_levels == 2'h0)
    else $error("pd clear");
  sda_scl_low_a: assert property ($past(i_nrst) && $changed(o_sda_oe) |-> !i_scl)
    else $error("sda moved");
  // Main scenarios reached
  cover property (o_sda_oe);
  cover property (i_powerdown && !o_powerdown_config_retain);
  cover property (o_out0_hiz);
endmodule : cfg_regs_checker
bind clock_buffer_config_regs cfg_regs_checker u_cfg_regs_checker (
  .i_mclk, .i_nrst, .i_scl, .i_powerdown, .i_output0_enable_bit, .i_out0_pin_enable, .o_sda_oe,
  .o_freq_pick, .o_feedback_edge_speed, .o_powerdown_config_retain, .o_stopped_output_levels,
  .o_out0_stopped, .o_out0_true_level, .o_out0_comp_level, .o_out0_hiz);
`default_nettype wire

// *** verification/clock_buffer_config_regs_test.sv ***
`default_nettype none
module clock_buffer_config_regs_test import clkbuf_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Arbitrary device address
  localparam logic [6:0] DEV = 7'h35;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_powerdown = 1'b0;
  logic i_output0_enable_bit = 1'b1;
  logic i_out0_pin_enable = 1'b1;
  logic i_scl, i_sda, host_low, o_sda_o, o_sda_oe, o_feedback_edge_speed;
  logic o_powerdown_config_retain, o_out0_stopped, o_out0_true_level, o_out0_comp_level;
  logic o_out0_hiz;
  logic [1:0] o_freq_pick, o_feedback_out_impedance, o_output0_impedance_sel;
  logic [1:0] o_stopped_output_levels;
  int fail_count = 0;
  int compares = 0;
  `define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
  // Pull-up: low when any party pulls
  assign i_sda = !(host_low || o_sda_oe);
  clock_buffer_config_regs #(.IMP_VARIANT(VARIANT_100)) u_clock_buffer_config_regs (
    .i_mclk, .i_nrst, .i_slave_addr(DEV), .i_scl, .i_sda, .o_sda_o, .o_sda_oe, .i_powerdown,
    .i_output0_enable_bit, .i_out0_pin_enable, .o_freq_pick, .o_feedback_edge_speed,
    .o_feedback_out_impedance, .o_output0_impedance_sel, .o_stopped_output_levels,
    .o_powerdown_config_retain, .o_out0_stopped, .o_out0_true_level, .o_out0_comp_level,
    .o_out0_hiz);
  host_model u_host_model (.i_mclk, .i_sda, .o_scl(i_scl), .o_sda_low(host_low));
  // 20 MHz clock
  initial begin
    forever #25 i_mclk = ~i_mclk;
  end
  // Write address phase, then index
  task automatic hdr(input logic [7:0] idx);
    logic a;
    u_host_model.frame(1'b0, 1'b1);
    u_host_model.put({DEV, 1'b0}, a);
    `CHK("addr ack", 1'b1, a)
    u_host_model.put(idx, a);
  endtask : hdr
  // Count byte sent, though not enforced
  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
    logic a;
    hdr(idx);
    u_host_model.put(8'(d.size()), a);
    foreach (d[i]) u_host_model.put(d[i], a);
    u_host_model.frame(1'b1, 1'b0);
  endtask : wr
  // Length byte, then bytes from idx; last refused
  task automatic rd(input logic [7:0] idx, input logic [7:0] c, input logic [7:0] e[$]);
    logic a;
    logic [7:0] v;
    hdr(idx);
    u_host_model.frame(1'b0, 1'b1);
    u_host_model.put({DEV, 1'b1}, a);
    u_host_model.get(1'b0, v);
    `CHK("count", c, v)
    foreach (e[i]) begin
      u_host_model.get(i == e.size() - 1, v);
      `CHK("data", e[i], v)
    end
    u_host_model.frame(1'b1, 1'b0);
  endtask : rd
  // Whole bank after reset
  task automatic t_reset();
    `CHK("slew", 1'b1, o_feedback_edge_speed)
    `CHK("sda out", 1'b0, o_sda_o)
    rd(8'h03, 8'h08, '{8'hc5, 8'h00, {REVISION_CODE, VENDOR_CODE}, 8'hc5, 8'h08, 8'h00,
      8'h00, 8'h40, {IMP_100, 6'h00}, {IMP_100, 6'h00}});
  endtask : t_reset
  // Code applies only when enabled; 11 ignored
  task automatic t_freq();
    logic [10:0] t[4] = '{{8'h28, 2'h1, 1'b0}, {8'h31, 2'h2, 1'b1}, {8'h39, 2'h2, 1'b1},
      {8'h0b, 2'h2, 1'b1}};
    foreach (t[i]) begin
      wr(8'h03, '{t[i][10:3]});
      `CHK("freq", t[i][2:1], o_freq_pick)
      `CHK("slew", t[i][0], o_feedback_edge_speed)
    end
    rd(8'h03, 8'h08, '{8'hcd});
  endtask : t_freq
  // Reserved and read-only places keep defaults
  task automatic t_bank();
    wr(8'h04, '{8'hff, 8'h00, 8'h12, 8'h03, 8'hff, 8'hff, 8'h00, 8'h43, 8'h7f});
    `CHK("fb imp", IMP_85, o_feedback_out_impedance)
    `CHK("out0 imp", IMP_85, o_output0_impedance_sel)
    rd(8'h04, 8'h03, '{8'h00, {REVISION_CODE, VENDOR_CODE}, 8'h12, 8'h03, 8'h00, 8'h00,
      8'h00, 8'h43, 8'h40});
  endtask : t_bank
  // Enable bit low forces every stop state
  task automatic t_stop();
    logic [2:0] lv[4] = '{3'b000, 3'b001, 3'b100, 3'b010};
    i_output0_enable_bit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h0b, '{{IMP_85, 4'h0, 2'(i)}});
      `CHK("stopped", 1'b1, o_out0_stopped)
      `CHK("levels", lv[i], {o_out0_true_level, o_out0_comp_level, o_out0_hiz})
      `CHK("stop field", 2'(i), o_stopped_output_levels)
    end
    i_output0_enable_bit = 1'b1;
    u_host_model.wt();
    `CHK("stopped", 1'b0, o_out0_stopped)
  endtask : t_stop
  // Retain off clears the bank, then on keeps it
  task automatic t_pd();
    for (int k = 0; k < 2; k++) begin
      wr(8'h03, '{8'h30});
      i_powerdown = 1'b1;
      u_host_model.wt();
      i_powerdown = 1'b0;
      `CHK("retain", 1'b1, o_powerdown_config_retain)
      `CHK("freq", k ? 2'h2 : 2'h0, o_freq_pick)
      `CHK("slew", k ? 1'b0 : 1'b1, o_feedback_edge_speed)
      `CHK("fb imp", IMP_100, o_feedback_out_impedance)
    end
  endtask : t_pd
  // Counts, verdict, end of run
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // Reset, then the scenarios
  initial begin
    repeat (8) @(posedge i_mclk);
    #1;
    i_nrst = 1'b1;
    u_host_model.wt();
    t_reset();
    t_freq();
    t_bank();
    t_stop();
    t_pd();
    close_out();
  end
  // Watchdog, about four times the expected run
  initial begin
    repeat (40000) @(posedge i_mclk);
    fail_count++;
    close_out();
  end
endmodule : clock_buffer_config_regs_test
`default_nettype wire

// *** verification/host_model.sv ***
`default_nettype none
module host_model (
  // Clock
  input wire logic i_mclk,
  // Resolved data line, pulled up
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus; clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Four clocks a phase, twice the minimum
  task automatic wt();
    repeat (4) @(posedge i_mclk);
    #1;
  endtask : wt
  // Start is frame(0,1), stop is frame(1,0)
  task automatic frame(input logic a, input logic b);
    o_sda_low = a;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_low = b;
    wt();
    o_scl = !b;
    wt();
  endtask : frame
  // Data changes only while the clock is low
  task automatic bit_c(input logic b, output logic s);
    o_sda_low = !b;
    wt();
    o_scl = 1'b1;
    wt();
    s = i_sda;
    o_scl = 1'b0;
    wt();
  endtask : bit_c
  // MSB first, ninth clock is the acknowledge slot
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'b1, s);
    ack = !s;
  endtask : put
  // Acknowledge unless last
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      d[i] = s;
    end
    bit_c(last, s);
  endtask : get
endmodule : host_model
`default_nettype wire
